// *** design/csd_pkg.sv ***
package csd_pkg;
    // register indices; byte address is four times the index
    localparam logic [31:0] csd_idx_port7_sel = 32'h0000_df27;
    localparam logic [31:0] csd_idx_bus_ctrl = 32'h0000_df40;
    localparam logic [31:0] csd_idx_speed = 32'h0000_df41;
    localparam logic [31:0] csd_idx_access = 32'h0000_df48;
    localparam logic [31:0] csd_idx_status = 32'h0000_df4c;
    localparam logic [31:0] csd_off_port7_sel = 32'h0003_7c9c;
    localparam logic [31:0] csd_off_bus_ctrl = 32'h0003_7d00;
    localparam logic [31:0] csd_off_speed = 32'h0003_7d04;
    localparam logic [31:0] csd_off_access = 32'h0003_7d20;
    localparam logic [31:0] csd_off_status = 32'h0003_7d30;
    localparam logic [7:0] csd_rst_port7 = 8'h00;
    localparam logic [7:0] csd_rst_bus_ctrl = 8'h00;
    localparam logic [7:0] csd_rst_speed = 8'h00;
    localparam int csd_bus_rom_en_bit = 7;
    localparam int csd_spd_ext_ram_bit = 2;
    localparam int csd_spd_cache_bit = 3;
    localparam int csd_spd_fast_bit = 7;
    localparam int csd_acc_valid_bit = 24;
    localparam logic [3:0] csd_stretch_cycles = 4'h2;
    localparam int csd_sel_pe = 0;
    localparam int csd_sel_cop = 1;
    localparam int csd_sel_onchip = 2;
    localparam int csd_sel_cache = 3;
    localparam int csd_sel_rom = 4;
    localparam int csd_sel_low = 5;
    localparam int csd_sel_mid = 6;
    localparam int csd_sel_high = 7;
    typedef enum logic [1:0] {csd_ph_low, csd_ph_high} csd_phase_type;
endpackage

// *** design/csd_decoder.sv ***
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module csd_decoder (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [7:0] chip_select_n,
    output logic [7:0] port7_pin_oe,
    output logic processor_clock
);
    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] csd_decode(input logic [23:0] a, input logic ext_ram,
                                             input logic rom_en);
        logic [7:0] s;
        logic b0;
        logic dfpage;
        s = 8'h00;
        b0 = (a[23:16] == 8'h00);
        dfpage = b0 && (a[15:8] == 8'hdf);
        if (a[23:22] == 2'b11) begin
            s[csd_pkg::csd_sel_high] = 1'b1;
        end else if (a[23] ^ a[22]) begin
            s[csd_pkg::csd_sel_mid] = 1'b1;
        end else if (!b0) begin
            s[csd_pkg::csd_sel_low] = 1'b1;
        end else if (dfpage && a[7:6] == 2'b11) begin
            s[csd_pkg::csd_sel_cop] = 1'b1;
        end else if (dfpage && a[7:5] == 3'b000) begin
            s[csd_pkg::csd_sel_pe] = 1'b1;
        end else if (dfpage) begin
            s[csd_pkg::csd_sel_onchip] = 1'b1;
        end else if (a[15:13] == 3'b111) begin
            if (rom_en) begin
                s[csd_pkg::csd_sel_onchip] = 1'b1;
            end else begin
                s[csd_pkg::csd_sel_rom] = 1'b1;
            end
        end else if (a[15]) begin
            s[csd_pkg::csd_sel_rom] = 1'b1;
        end else if (a[15:9] == 7'h00 && !ext_ram) begin
            s[csd_pkg::csd_sel_onchip] = 1'b1;
        end else begin
            s[csd_pkg::csd_sel_cache] = 1'b1;
        end
        return s; // exactly one bit per address
    endfunction

    ////////////////////////////////////////////////////////////////
    logic [7:0] port7_q, port7_d;
    logic [7:0] busctl_q, busctl_d;
    logic [7:0] speed_q, speed_d;
    logic [23:0] acc_q, acc_d;
    logic acc_v_q, acc_v_d;
    logic wr_pend_q, wr_pend_d;
    logic [31:0] waddr_q, waddr_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0] csn_q, csn_d;
    logic [7:0] oe_q, oe_d;
    logic clk_q, clk_d;
    logic [3:0] cnt_q, cnt_d;
    logic slow_q, slow_d;
    logic [7:0] sel;
    logic take;

    assign take = hsel && hready && htrans[1];
    assign sel = csd_decode(acc_q, speed_q[csd_pkg::csd_spd_ext_ram_bit],
                            busctl_q[csd_pkg::csd_bus_rom_en_bit]);

    // registers: writes land one cycle after their address phase, zero wait
    always_comb begin
        port7_d = port7_q;
        busctl_d = busctl_q;
        speed_d = speed_q;
        acc_d = acc_q;
        acc_v_d = acc_v_q;
        wr_pend_d = take && hwrite;
        waddr_d = take ? haddr : waddr_q;
        rdata_d = 32'h0000_0000;
        if (wr_pend_q) begin
            case (waddr_q)
                csd_pkg::csd_off_port7_sel: port7_d = hwdata[7:0];
                csd_pkg::csd_off_bus_ctrl: busctl_d = hwdata[7:0];
                csd_pkg::csd_off_speed: speed_d = hwdata[7:0];
                csd_pkg::csd_off_access: begin
                    acc_d = hwdata[23:0];
                    acc_v_d = hwdata[csd_pkg::csd_acc_valid_bit];
                end
                default: begin
                end
            endcase
        end
        if (take && !hwrite) begin
            case (haddr)
                csd_pkg::csd_off_port7_sel: rdata_d = {24'h000000, port7_q};
                csd_pkg::csd_off_bus_ctrl: rdata_d = {24'h000000, busctl_q};
                csd_pkg::csd_off_speed: rdata_d = {24'h000000, speed_q};
                csd_pkg::csd_off_access: rdata_d = {7'h00, acc_v_q, acc_q};
                csd_pkg::csd_off_status: rdata_d = {15'h0000, slow_q, sel, ~csn_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port7_q <= csd_pkg::csd_rst_port7;
            busctl_q <= csd_pkg::csd_rst_bus_ctrl;
            speed_q <= csd_pkg::csd_rst_speed;
            acc_q <= 24'h000000;
            acc_v_q <= 1'b0;
            wr_pend_q <= 1'b0;
            waddr_q <= 32'h0000_0000;
            rdata_q <= 32'h0000_0000;
        end else begin
            port7_q <= port7_d;
            busctl_q <= busctl_d;
            speed_q <= speed_d;
            acc_q <= acc_d;
            acc_v_q <= acc_v_d;
            wr_pend_q <= wr_pend_d;
            waddr_q <= waddr_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // selects and clock stretch; cache (and on-chip) stays fast
    always_comb begin
        csn_d = 8'hff;
        oe_d = port7_q;
        if (acc_v_q) begin
            csn_d = ~sel;
        end
        slow_d = acc_v_q && !sel[csd_pkg::csd_sel_cache] && !sel[csd_pkg::csd_sel_onchip]
                 && !speed_q[csd_pkg::csd_spd_fast_bit];
        clk_d = clk_q;
        cnt_d = cnt_q;
        if (slow_q && cnt_q != csd_pkg::csd_stretch_cycles) begin
            cnt_d = cnt_q + 4'h1; // both phases stretched
        end else begin
            cnt_d = 4'h0;
            clk_d = ~clk_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            csn_q <= 8'hff;
            oe_q <= 8'h00;
            clk_q <= 1'b0;
            cnt_q <= 4'h0;
            slow_q <= 1'b0;
        end else begin
            csn_q <= csn_d;
            oe_q <= oe_d;
            clk_q <= clk_d;
            cnt_q <= cnt_d;
            slow_q <= slow_d;
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign chip_select_n = csn_q;
    assign port7_pin_oe = oe_q;
    assign processor_clock = clk_q;

    ////////////////////////////////////////////////////////////////
    a_one_select: assert property (@(posedge hclk) disable iff (!hresetn)
        acc_v_q |=> $countones(~csn_q) == 1) else $error("not one select");
    a_idle_high: assert property (@(posedge hclk) disable iff (!hresetn)
        !acc_v_q |=> csn_q == 8'hff) else $error("select active while idle");
    a_df_no_rom: assert property (@(posedge hclk) disable iff (!hresetn)
        (acc_v_q && acc_q[23:8] == 16'h00df) |=> csn_q[csd_pkg::csd_sel_rom] && csn_q[csd_pkg::csd_sel_low])
        else $error("df page hit rom or low");
    a_rom_mask: assert property (@(posedge hclk) disable iff (!hresetn)
        (acc_v_q && busctl_q[csd_pkg::csd_bus_rom_en_bit] && acc_q[23:13] == 11'h007)
        |=> csn_q[csd_pkg::csd_sel_rom]) else $error("rom select with on-chip rom");
    a_cache_low: assert property (@(posedge hclk) disable iff (!hresetn)
        (acc_v_q && acc_q[23:9] == 15'h0000)
        |=> csn_q[csd_pkg::csd_sel_cache] == !$past(speed_q[csd_pkg::csd_spd_ext_ram_bit]))
        else $error("cache select wrong for low ram");
    a_high_bank: assert property (@(posedge hclk) disable iff (!hresetn)
        (acc_v_q && acc_q[23:22] == 2'b11) |=> !csn_q[csd_pkg::csd_sel_high])
        else $error("high bank missed");
    a_mid_bank: assert property (@(posedge hclk) disable iff (!hresetn)
        (acc_v_q && acc_q[23] != acc_q[22]) |=> !csn_q[csd_pkg::csd_sel_mid])
        else $error("mid bank missed");
    a_cop_win: assert property (@(posedge hclk) disable iff (!hresetn)
        (acc_v_q && acc_q[23:6] == 18'h037f) |=> !csn_q[csd_pkg::csd_sel_cop])
        else $error("coprocessor window missed");
    a_pe_win: assert property (@(posedge hclk) disable iff (!hresetn)
        (acc_v_q && acc_q[23:5] == 19'h006f8) |=> !csn_q[csd_pkg::csd_sel_pe])
        else $error("expansion window missed");
    a_oe_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> oe_q == $past(port7_q)) else $error("pin enable not from port7");
    a_fast_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
        !slow_q |=> clk_q != $past(clk_q)) else $error("fast clock did not toggle");
    a_slow_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        ($rose(slow_q) && cnt_q == 4'h0) |=> clk_q == $past(clk_q)) else $error("slow phase not held");
endmodule

// *** tb/csd_mem_model.sv ***
`timescale 1ns/1ps
module csd_mem_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] chip_select_n,
    input wire logic [7:0] port7_pin_oe,
    input wire logic processor_clock,
    output logic [7:0] phase_len,
    output logic [7:0] seen_sel
);
    logic [7:0] cnt_q;
    logic last_q;
    ////////////////////////////////////////////////////////////////////////
    // memories finish inside one phase, so log each phase length
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 8'h00;
            last_q <= 1'b0;
            phase_len <= 8'h00;
            seen_sel <= 8'h00;
        end else begin
            last_q <= processor_clock;
            if (processor_clock != last_q) begin
                phase_len <= cnt_q + 8'h01;
                cnt_q <= 8'h00;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
            // a pin left as port line is not a select for the memory
            seen_sel <= ~chip_select_n & port7_pin_oe;
        end
    end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, processor_clock;
    logic [7:0] chip_select_n, port7_pin_oe, phase_len, seen_sel;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    localparam logic [23:0] addrs[17] = '{24'hc00000, 24'h400000, 24'hbfffff, 24'h3f0000, 24'h010000,
        24'h008000, 24'h00deff, 24'h00e000, 24'h000200, 24'h007fff, 24'h000100, 24'h00df00, 24'h00df1f,
        24'h00dfc0, 24'h00dfff, 24'h00df80, 24'h00df40};
    always #25 hclk = ~hclk;
    csd_decoder dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .chip_select_n(chip_select_n), .port7_pin_oe(port7_pin_oe),
        .processor_clock(processor_clock));
    csd_mem_model mem_u (.hclk(hclk), .hresetn(hresetn), .chip_select_n(chip_select_n),
        .port7_pin_oe(port7_pin_oe), .processor_clock(processor_clock), .phase_len(phase_len),
        .seen_sel(seen_sel));
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    // address phase held until hready, data taken at the following hready edge
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    function automatic int exp_idx(logic [23:0] a, logic rom, logic ext);
        if (a[23:22] == 2'h3) return 7;
        if (a[23:22] != 2'h0) return 6;
        if (a[23:16] != 8'h00) return 5;
        if (a[15:5] == 11'h6f8) return 0;
        if (a[15:6] == 10'h37f) return 1;
        if (a[15:8] == 8'hdf) return 2;
        if (a[15:13] == 3'h7) return rom ? 2 : 4;
        if (a[15]) return 4;
        if (a[15:9] == 7'h00) return ext ? 3 : 2;
        return 3;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        ahb(1'b0, csd_pkg::csd_off_port7_sel, 32'h0);
        chk("port7", {24'h0, csd_pkg::csd_rst_port7}, rd);
        ahb(1'b0, csd_pkg::csd_off_speed, 32'h0);
        chk("speed", {24'h0, csd_pkg::csd_rst_speed}, rd);
        ahb(1'b1, 32'h0000_df50, 32'hffff_ffff);
        ahb(1'b0, 32'h0000_df50, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("idle sel", 32'hff, {24'h0, chip_select_n});
        chk("resp okay", 32'h0, {31'h0, hresp});
    endtask
    task automatic t_decode;
        int k;
        ahb(1'b1, csd_pkg::csd_off_port7_sel, 32'hff);
        for (int m = 0; m < 4; m++) begin
            ahb(1'b1, csd_pkg::csd_off_bus_ctrl, 32'(m[0]) << csd_pkg::csd_bus_rom_en_bit);
            ahb(1'b1, csd_pkg::csd_off_speed, 32'(m[1]) << csd_pkg::csd_spd_ext_ram_bit);
            foreach (addrs[i]) begin
                k = exp_idx(addrs[i], m[0], m[1]);
                ahb(1'b1, csd_pkg::csd_off_access, {7'h0, 1'b1, addrs[i]});
                repeat (3) @(posedge hclk);
                chk("sel pins", {24'h0, ~(8'h01 << k)}, {24'h0, chip_select_n});
                ahb(1'b0, csd_pkg::csd_off_status, 32'h0);
                chk("status", {7'h0, k != 2 && k != 3, 8'h01 << k, 8'h01 << k}, rd[23:0]);
                chk("mem seen", {24'h0, 8'h01 << k}, {24'h0, seen_sel});
            end
        end
        ahb(1'b1, csd_pkg::csd_off_access, 32'h0);
        repeat (3) @(posedge hclk);
        chk("released", 32'hff, {24'h0, chip_select_n});
    endtask
    task automatic t_enable;
        ahb(1'b1, csd_pkg::csd_off_port7_sel, 32'h5a);
        repeat (3) @(posedge hclk);
        chk("oe", 32'h5a, {24'h0, port7_pin_oe});
    endtask
    task automatic t_clock(input logic [23:0] a, input logic fast, input logic [7:0] e);
        ahb(1'b1, csd_pkg::csd_off_speed, 32'(fast) << csd_pkg::csd_spd_fast_bit);
        ahb(1'b1, csd_pkg::csd_off_access, {7'h0, 1'b1, a});
        repeat (16) @(posedge hclk);
        chk("phase", {24'h0, e}, {24'h0, phase_len});
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_decode();
        t_enable();
        t_clock(24'hc00000, 1'b0, 8'(1 + csd_pkg::csd_stretch_cycles));
        t_clock(24'h000400, 1'b0, 8'h01);
        t_clock(24'hc00000, 1'b1, 8'h01);
        tally_and_finish();
    end
endmodule
